// ==== hw/rcrc_map.svh ====
// Register offsets, field positions, reset values and timing counts.
// Assumes one 20 MHz clock; included by the package and the radio control module.
`ifndef RCRC_MAP_SVH
`define RCRC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RCRC_A_PWR 8'h00
`define RCRC_A_FLAGS 8'h01
`define RCRC_A_STATUS 8'h02
`define RCRC_A_STATE 8'h03
`define RCRC_A_RSSI 8'h04
`define RCRC_A_THR 8'h05
`define RCRC_A_MDM_LO 8'h06
`define RCRC_A_MDM_HI 8'h07
`define RCRC_A_CORR 8'h08
`define RCRC_A_STROBE 8'h09
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RCRC_F_REG_ON 0
`define RCRC_F_CCA_FLAG 1
`define RCRC_F_AUTO_CRC 2
`define RCRC_RST_THR 8'hE0
`define RCRC_RST_HYST 3'h2
`define RCRC_RST_MODE 2'h3
// ----------------------------------------
// Strobe command codes
// ----------------------------------------
`define RCRC_C_RX_ON 8'h02
`define RCRC_C_CAL 8'h03
`define RCRC_C_CAL_IMM 8'h04
`define RCRC_C_TX_ON 8'h05
`define RCRC_C_TX_CCA 8'h06
`define RCRC_C_RF_OFF 8'h07
// ----------------------------------------
// Timing
// ----------------------------------------
`define RCRC_CLK_NS 50
`define RCRC_SYM_NS 16000
`define RCRC_RREG_UP_NS 20000
`define RCRC_SYM_CYC ((`RCRC_SYM_NS + `RCRC_CLK_NS - 1) / `RCRC_CLK_NS)
`define RCRC_TX_DLY_CYC (12 * `RCRC_SYM_CYC)
`define RCRC_RX_VLD_CYC (8 * `RCRC_SYM_CYC)
`define RCRC_RREG_CYC ((`RCRC_RREG_UP_NS + `RCRC_CLK_NS - 1) / `RCRC_CLK_NS)
`endif

// ==== hw/rcrc_pkg.sv ====
// Types of the radio control block: state enum and state record.
// Assumes the map header sits beside it.
`include "rcrc_map.svh"
package rcrc_pkg;
  // Operating states of the radio
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_SYNTH, ST_TX_WAIT, ST_TX} rcrc_state_e;
  // Whole state of the block
  typedef struct packed {
    rcrc_state_e st;
    logic [8:0] div;
    logic pwr_pd;
    logic [8:0] reg_cnt;
    logic reg_up;
    logic flag_reg;
    logic flag_cca;
    logic [7:0] thr;
    logic [2:0] hyst;
    logic [1:0] mode;
    logic auto_crc;
    logic [11:0] rx_cnt;
    logic [11:0] tx_cnt;
    logic [10:0] acc;
    logic [2:0] acc_n;
    logic [7:0] rssi;
    logic busy;
    logic cca;
    logic [9:0] corr_acc;
    logic [3:0] corr_n;
    logic [6:0] corr;
    logic [7:0] rdata;
    logic preamble;
    logic app_valid;
    logic [6:0] app_corr;
    logic [7:0] app_rssi;
    logic app_crc;
  } rcrc_regs_s;
endpackage

// ==== hw/rcrc_radio_ctrl.sv ====
// Radio control: state machine, regulator bring-up, signal strength,
// correlation and clear channel assessment behind a small register port.
// Assumes analog side inputs are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "rcrc_map.svh"
module rcrc_radio_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] rssi_in,
  input wire logic [6:0] corr_in,
  input wire logic sfd_det,
  input wire logic rx_data_valid,
  input wire logic frame_done,
  input wire logic crc_ok,
  input wire logic tx_done,
  input wire logic crystal_stable,
  output logic radio_regulator_powerdown,
  output logic synth_on,
  output logic rx_on,
  output logic tx_active,
  output logic preamble_start,
  output logic clear_channel,
  output logic [7:0] signal_strength_value,
  output logic append_valid,
  output logic [6:0] append_corr,
  output logic [7:0] append_rssi,
  output logic append_crc_ok
);
  import rcrc_pkg::*;

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  rcrc_regs_s s; // Registered state
  rcrc_regs_s next_s; // Next state
  logic stb; // Strobe register written
  logic tick; // One pulse per symbol period
  logic cmd_tx; // Any accepted transmit strobe
  logic e_clear; // Energy below threshold, with hysteresis
  logic m_clear; // Result of the selected mode
  logic signed [8:0] lower; // Threshold minus hysteresis

  assign stb = reg_wr && (reg_addr == `RCRC_A_STROBE);
  assign tick = (s.div == 9'(`RCRC_SYM_CYC - 1));

  // Clear channel decision from averaged strength and data valid, per mode
  always_comb begin
    lower = $signed({s.thr[7], s.thr}) - $signed({6'h00, s.hyst});
    if (s.busy) begin
      e_clear = $signed({s.rssi[7], s.rssi}) < lower;
    end else begin
      e_clear = $signed(s.rssi) < $signed(s.thr);
    end
    case (s.mode)
      2'h1: m_clear = e_clear;
      2'h2: m_clear = !rx_data_valid;
      2'h3: m_clear = e_clear && !rx_data_valid;
      default: m_clear = e_clear; // Reserved code behaves as energy mode
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // All next-state updates in one process; configuration only clears on rst_b
  always_comb begin
    next_s = s;
    cmd_tx = 1'b0;
    next_s.preamble = 1'b0;
    next_s.app_valid = 1'b0;
    next_s.div = tick ? 9'h000 : 9'(s.div + 9'h001);
    // Register writes; no power-mode clear of configuration
    if (reg_wr) begin
      case (reg_addr)
        `RCRC_A_PWR: next_s.pwr_pd = reg_wdata[0];
        `RCRC_A_THR: next_s.thr = reg_wdata;
        `RCRC_A_MDM_LO: begin
          next_s.mode = reg_wdata[1:0];
          next_s.auto_crc = reg_wdata[`RCRC_F_AUTO_CRC];
        end
        `RCRC_A_MDM_HI: next_s.hyst = reg_wdata[2:0];
        default: next_s.thr = s.thr;
      endcase
    end
    // Write-one-to-clear flags; a set in the same cycle wins below
    if (reg_wr && reg_addr == `RCRC_A_FLAGS) begin
      next_s.flag_reg = s.flag_reg && !reg_wdata[`RCRC_F_REG_ON];
      next_s.flag_cca = s.flag_cca && !reg_wdata[`RCRC_F_CCA_FLAG];
    end
    // Regulator start-up timer
    if (s.pwr_pd) begin
      next_s.reg_cnt = 9'h000;
      next_s.reg_up = 1'b0;
    end else if (!s.reg_up) begin
      if (s.reg_cnt == 9'(`RCRC_RREG_CYC - 1)) begin
        next_s.reg_up = 1'b1;
        next_s.flag_reg = 1'b1;
      end else begin
        next_s.reg_cnt = 9'(s.reg_cnt + 9'h001);
      end
    end
    // Radio state machine, driven by strobes, the transmit delay count and tx_done
    case (s.st)
      ST_IDLE: begin
        if (stb && (reg_wdata == `RCRC_C_CAL || reg_wdata == `RCRC_C_CAL_IMM)) begin
          next_s.st = ST_SYNTH;
        end else if (stb && reg_wdata == `RCRC_C_RX_ON) begin
          next_s.st = ST_RX;
        end else if (stb && reg_wdata == `RCRC_C_TX_ON) begin
          cmd_tx = 1'b1;
        end
      end
      ST_RX: begin
        if (stb && (reg_wdata == `RCRC_C_CAL || reg_wdata == `RCRC_C_CAL_IMM)) begin
          next_s.st = ST_SYNTH;
        end else if (stb && reg_wdata == `RCRC_C_TX_ON) begin
          cmd_tx = 1'b1;
        end else if (stb && reg_wdata == `RCRC_C_TX_CCA && s.cca) begin
          cmd_tx = 1'b1; // Busy channel drops the strobe
        end
      end
      ST_SYNTH: begin
        // Synth runs but waits for an explicit transmit
        if (stb && reg_wdata == `RCRC_C_TX_ON) begin
          cmd_tx = 1'b1;
        end else if (stb && reg_wdata == `RCRC_C_RX_ON) begin
          next_s.st = ST_RX;
        end
      end
      ST_TX_WAIT: begin
        if (s.tx_cnt == 12'(`RCRC_TX_DLY_CYC - 1)) begin
          next_s.st = ST_TX;
          next_s.preamble = 1'b1;
        end else begin
          next_s.tx_cnt = 12'(s.tx_cnt + 12'h001);
        end
      end
      ST_TX: begin
        if (tx_done) begin
          next_s.st = ST_RX; // Frame sent, back to listening
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    if (cmd_tx) begin
      next_s.st = ST_TX_WAIT;
      next_s.tx_cnt = 12'h000;
    end
    if (stb && reg_wdata == `RCRC_C_RF_OFF) begin
      next_s.st = ST_IDLE;
      next_s.preamble = 1'b0;
    end
    // Receiver (re)entry restarts the validity window
    if (next_s.st == ST_RX && s.st != ST_RX) begin
      next_s.rx_cnt = 12'h000;
      next_s.cca = 1'b0;
      next_s.busy = 1'b0;
    end
    // Strength averaging; frozen in idle
    if (s.st != ST_IDLE && tick) begin
      if (s.acc_n == 3'h7) begin
        next_s.acc = 11'h000;
        next_s.rssi = 8'(($signed(s.acc) + $signed({{3{rssi_in[7]}}, rssi_in})) >>> 3);
      end else begin
        next_s.acc = 11'($signed(s.acc) + $signed({{3{rssi_in[7]}}, rssi_in}));
      end
      next_s.acc_n = 3'(s.acc_n + 3'h1);
    end
    // Clear channel only once receiver has run eight symbols
    if (s.st == ST_RX) begin
      if (s.rx_cnt != 12'(`RCRC_RX_VLD_CYC)) begin
        next_s.rx_cnt = 12'(s.rx_cnt + 12'h001);
      end else begin
        next_s.cca = m_clear;
        next_s.busy = !e_clear;
        if (m_clear && !s.cca) begin
          next_s.flag_cca = 1'b1;
        end
      end
    end
    // Correlation average over eight symbols after the delimiter
    if (s.st == ST_RX && sfd_det) begin
      next_s.corr_acc = 10'h000;
      next_s.corr_n = 4'h0;
    end else if (tick && s.corr_n != 4'h8) begin
      next_s.corr_acc = 10'(s.corr_acc + {3'h0, corr_in});
      next_s.corr_n = 4'(s.corr_n + 4'h1);
      if (s.corr_n == 4'h7) begin
        next_s.corr = 7'((s.corr_acc + {3'h0, corr_in}) >> 3);
      end
    end
    // Status append at frame end
    if (s.st == ST_RX && frame_done && s.auto_crc) begin
      next_s.app_valid = 1'b1;
      next_s.app_corr = s.corr;
      next_s.app_rssi = s.rssi;
      next_s.app_crc = crc_ok;
    end
    // Read data, one cycle after the strobe
    next_s.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RCRC_A_PWR: next_s.rdata = {7'h00, s.pwr_pd};
        `RCRC_A_FLAGS: next_s.rdata = {6'h00, s.flag_cca, s.flag_reg};
        `RCRC_A_STATUS: next_s.rdata = {5'h00, crystal_stable, s.st == ST_TX, s.cca};
        `RCRC_A_STATE: next_s.rdata = 8'(s.st);
        `RCRC_A_RSSI: next_s.rdata = s.rssi;
        `RCRC_A_THR: next_s.rdata = s.thr;
        `RCRC_A_MDM_LO: next_s.rdata = {5'h00, s.auto_crc, s.mode};
        `RCRC_A_MDM_HI: next_s.rdata = {5'h00, s.hyst};
        `RCRC_A_CORR: next_s.rdata = {1'b0, s.corr};
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset; the only path that clears configuration
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.pwr_pd <= 1'b1;
      s.thr <= `RCRC_RST_THR;
      s.hyst <= `RCRC_RST_HYST;
      s.mode <= `RCRC_RST_MODE;
      s.corr_n <= 4'h8;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign reg_rdata = s.rdata;
  assign radio_regulator_powerdown = s.pwr_pd;
  assign synth_on = (s.st != ST_IDLE);
  assign rx_on = (s.st == ST_RX);
  assign tx_active = (s.st == ST_TX);
  assign preamble_start = s.preamble;
  assign clear_channel = s.cca;
  assign signal_strength_value = s.rssi;
  assign append_valid = s.app_valid;
  assign append_corr = s.app_corr;
  assign append_rssi = s.app_rssi;
  assign append_crc_ok = s.app_crc;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_cmd(logic [7:0] c);
    reg_wr && reg_addr == `RCRC_A_STROBE && reg_wdata == c;
  endsequence
  sequence s_rx_busy;
    s.st == ST_RX && !s.cca;
  endsequence
  a_rf_off_idle: assert property (s_cmd(`RCRC_C_RF_OFF) |=> s.st == ST_IDLE)
    else $error("radio off strobe did not reach idle");
  a_busy_no_tx: assert property (s_cmd(`RCRC_C_TX_CCA) and s_rx_busy |=> s.st == ST_RX)
    else $error("transmit-if-clear taken on busy channel");
  a_cca_window: assert property (s.st == ST_RX && s.cca |-> s.rx_cnt == 12'(`RCRC_RX_VLD_CYC))
    else $error("clear channel before eight symbols");
  a_reg_flag_set: assert property ($rose(s.reg_up) |-> s.flag_reg ##1 s.reg_up)
    else $error("regulator flag missing");
  a_idle_hold: assert property (s.st == ST_IDLE |=> $stable(s.rssi) && !$rose(s.flag_cca))
    else $error("idle changed strength or flag");
  a_state_read: assert property (reg_rd && reg_addr == `RCRC_A_STATE |=> reg_rdata == 8'($past(s.st)))
    else $error("state readback wrong");
  a_preamble_time: assert property (preamble_start |-> $past(s.st) == ST_TX_WAIT && $past(s.tx_cnt) == 12'(`RCRC_TX_DLY_CYC - 1))
    else $error("preamble not twelve symbols after strobe");
  a_synth_hold: assert property (s.st == ST_SYNTH && !reg_wr |=> s.st == ST_SYNTH)
    else $error("synth left without strobe");
  a_append_out: assert property (s.st == ST_RX && frame_done && s.auto_crc |=> append_valid && append_rssi == $past(s.rssi))
    else $error("append status missing");
  a_cca_flag: assert property ($rose(s.cca) |-> s.flag_cca)
    else $error("clear channel flag not set");
endmodule
`default_nettype wire

// ==== test/rcrc_rf_model.sv ====
// Far-side model: channel energy, packet correlation, data-valid window
// and transmitter completion. Assumes the bench steers it by its requests.
`timescale 1ns/1ps
`default_nettype none
module rcrc_rf_model #(
  parameter int TX_LEN = 40
) (
  input wire logic mclk,
  input wire logic tx_active,
  input wire logic sfd_req,
  input wire logic frame_req,
  input wire logic [7:0] level,
  input wire logic [6:0] quality,
  output logic [7:0] rssi_in,
  output logic [6:0] corr_in,
  output logic sfd_det,
  output logic rx_data_valid,
  output logic frame_done,
  output logic crc_ok,
  output logic tx_done
);
  // ----------------------------------------
  // Channel state
  // ----------------------------------------
  logic in_frame = 1'b0; // Between delimiter and frame end
  logic done_q = 1'b0; // Known level from time zero
  int tx_cnt = 0; // Cycles spent transmitting
  assign rssi_in = level;
  assign corr_in = quality;
  assign sfd_det = sfd_req;
  assign frame_done = frame_req;
  assign crc_ok = 1'b1; // Every frame arrives intact
  assign rx_data_valid = in_frame;
  assign tx_done = done_q;
  // Data counts as valid from delimiter until the frame ends
  always @(posedge mclk) begin
    if (sfd_req) begin
      in_frame <= 1'b1;
    end else if (frame_req) begin
      in_frame <= 1'b0;
    end
  end
  // Transmitter reports completion TX_LEN + 1 cycles after it starts
  always @(posedge mclk) begin
    tx_cnt <= tx_active ? tx_cnt + 1 : 0;
    done_q <= tx_active && (tx_cnt == TX_LEN);
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the radio control block.
// Assumes the far-side model beside it and one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rcrc_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, crystal_stable = 1'b0;
  logic sfd_req = 1'b0, frame_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, level = 8'hD8, rd_val;
  logic [6:0] quality = 7'h64;
  logic [7:0] reg_rdata, rssi_in, signal_strength_value, append_rssi;
  logic [6:0] corr_in, append_corr;
  logic sfd_det, rx_data_valid, frame_done, crc_ok, tx_done, radio_regulator_powerdown;
  logic synth_on, rx_on, tx_active, preamble_start, clear_channel, append_valid, append_crc_ok;
  int fails = 0, check_count = 0, n;
  always #25 mclk = ~mclk;
  rcrc_radio_ctrl dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rssi_in, .corr_in, .sfd_det, .rx_data_valid, .frame_done, .crc_ok, .tx_done,
    .crystal_stable, .radio_regulator_powerdown, .synth_on, .rx_on, .tx_active,
    .preamble_start, .clear_channel, .signal_strength_value, .append_valid, .append_corr,
    .append_rssi, .append_crc_ok);
  rcrc_rf_model #(.TX_LEN(40)) rf (.mclk, .tx_active, .sfd_req, .frame_req, .level,
    .quality, .rssi_in, .corr_in, .sfd_det, .rx_data_valid, .frame_done, .crc_ok, .tx_done);
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk(rd_val, exp);
  endtask
  // Land past the edge so outputs are settled
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Energy steps land on a clock edge like every other input
  task automatic set_level(input logic [7:0] v);
    @(posedge mclk);
    level <= v;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rchk(8'h03, 8'h00);
    wr(8'h03, 8'h04);
    rchk(8'h03, 8'h00);
    rchk(8'h05, 8'hE0);
    rchk(8'h06, 8'h03);
    rchk(8'h07, 8'h02);
    rchk(8'h3C, 8'h00);
    rchk(8'h02, 8'h00);
    @(posedge mclk);
    crystal_stable <= 1'b1;
    rchk(8'h02, 8'h04);
  endtask
  task automatic t_reg;
    wr(8'h00, 8'h00);
    cyc(1);
    chk({7'h00, radio_regulator_powerdown}, 8'h00);
    cyc(380);
    rchk(8'h01, 8'h00);
    cyc(30);
    rchk(8'h01, 8'h01);
    wr(8'h01, 8'h01);
  endtask
  // Clear channel: validity delay, threshold, hysteresis, gated strobe
  task automatic t_cca;
    wr(8'h09, 8'h02);
    cyc(2);
    chk({7'h00, rx_on}, 8'h01);
    cyc(2400);
    chk({7'h00, clear_channel}, 8'h00);
    cyc(3000);
    chk({7'h00, clear_channel}, 8'h01);
    rchk(8'h04, 8'hD8);
    rchk(8'h01, 8'h02);
    wr(8'h01, 8'h02);
    set_level(8'hEC);
    cyc(5200);
    chk({7'h00, clear_channel}, 8'h00);
    wr(8'h09, 8'h06);
    cyc(2);
    rchk(8'h03, 8'h01);
    set_level(8'hDF);
    cyc(5200);
    chk({7'h00, clear_channel}, 8'h00);
    set_level(8'hD8);
    cyc(5200);
    chk({7'h00, clear_channel}, 8'h01);
  endtask
  // Both transmit strobes, preamble twelve symbols later
  task automatic t_tx(input logic [7:0] code);
    wr(8'h09, code);
    n = 0;
    while (!preamble_start && n < 5000) begin
      cyc(1);
      n++;
    end
    chk({7'h00, n >= 3839 && n <= 3842}, 8'h01);
    chk({7'h00, tx_active}, 8'h01);
    cyc(60);
    chk({7'h00, rx_on}, 8'h01);
  endtask
  task automatic t_cal(input logic [7:0] code);
    wr(8'h09, code);
    cyc(2);
    rchk(8'h03, 8'h02);
    cyc(400);
    chk({7'h00, tx_active}, 8'h00);
    wr(8'h09, 8'h07);
    cyc(2);
    rchk(8'h03, 8'h00);
    chk({7'h00, synth_on}, 8'h00);
  endtask
  // Correlation over a frame, every mode code, and the appended trailer
  task automatic t_corr;
    wr(8'h06, 8'h07);
    wr(8'h09, 8'h02);
    sfd_req <= 1'b1;
    @(posedge mclk);
    sfd_req <= 1'b0;
    cyc(2700);
    rchk(8'h08, 8'h64);
    chk({7'h00, clear_channel}, 8'h00);
    // Data valid and energy low: only the energy-based codes see clear
    wr(8'h06, 8'h05);
    cyc(2);
    chk({7'h00, clear_channel}, 8'h01);
    wr(8'h06, 8'h06);
    cyc(2);
    chk({7'h00, clear_channel}, 8'h00);
    wr(8'h06, 8'h04);
    cyc(2);
    chk({7'h00, clear_channel}, 8'h01);
    wr(8'h06, 8'h07);
    @(posedge mclk);
    frame_req <= 1'b1;
    @(posedge mclk);
    frame_req <= 1'b0;
    #1;
    n = 0;
    while (!append_valid && n < 10) begin
      cyc(1);
      n++;
    end
    chk({7'h00, append_valid}, 8'h01);
    chk({1'b0, append_corr}, 8'h64);
    chk(append_rssi, 8'hD8);
    chk({7'h00, append_crc_ok}, 8'h01);
  endtask
  task automatic t_hold;
    wr(8'h09, 8'h07);
    set_level(8'hEC);
    cyc(5200);
    chk(signal_strength_value, 8'hD8);
    rchk(8'h05, 8'hE0);
    rchk(8'h06, 8'h07);
  endtask
  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Run needs about 38000 cycles; cut a hang well past that
  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_reg();
    t_cca();
    t_tx(8'h06);
    t_tx(8'h05);
    t_cal(8'h03);
    t_cal(8'h04);
    t_corr();
    t_hold();
    end_sim();
  end
endmodule
`default_nettype wire
